// ### tb_uacl_link.sv
// Self-checking testbench for the autobaud command link
`timescale 1ns/1ps
module tb_uacl_link;
  import uacl_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic rspValid;
  logic rspLast;
  logic ackReq;
  logic ackOk;
  logic [7:0] rspByte;
  logic rxLine, txLine, rstPinOut, rstPinOeN, pinReset, locked, cmdValid, cmdBusy, rspReady;
  logic hostPull;
  logic [PER_W-1:0] bitPeriod;
  logic [7:0] cmdByte;
  logic [POS_W-1:0] cmdPos;
  logic [7:0] cbq[$];
  logic [POS_W-1:0] cpq[$];
  int failCount = 0;
  int testsRun = 0;
  int cyc = 0;
  // Pulled-up pin: low only while someone pulls it
  wire rstPinIn = (rstPinOeN ? 1'b1 : rstPinOut) & ~hostPull;
  always #2 core_clk = ~core_clk;
  uacl_link #(.PER_MAX(64), .PER_MIN(8)) dut (
    .core_clk(core_clk), .reset(reset), .rxLine(rxLine), .txLine(txLine), .rstPinIn(rstPinIn),
    .rstPinOut(rstPinOut), .rstPinOeN(rstPinOeN), .pinReset(pinReset), .locked(locked),
    .bitPeriod(bitPeriod), .cmdByte(cmdByte), .cmdValid(cmdValid), .cmdPos(cmdPos),
    .cmdBusy(cmdBusy), .rspValid(rspValid), .rspByte(rspByte), .rspLast(rspLast),
    .ackReq(ackReq), .ackOk(ackOk), .rspReady(rspReady)
  );
  uacl_host_model host (.core_clk(core_clk), .txLine(txLine), .rxLine(rxLine), .hostPull(hostPull));
  // ********
  // Monitors
  // ********
  always @(negedge core_clk)
  begin
    if (cmdValid === 1'b1)
    begin
      cbq.push_back(cmdByte);
      cpq.push_back(cmdPos);
    end
  end
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failCount++;
      printVerdict();
    end
  end
  // ********
  // Helpers
  // ********
  task automatic wt(input int n);
    repeat (n) @(negedge core_clk);
  endtask : wt
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    testsRun++;
    if (got !== exp)
    begin
      failCount++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk
  task automatic rxPop(input string nm, input logic [7:0] exp);
    int i;
    i = 0;
    while (host.q.size() == 0 && i < 3000)
    begin
      wt(1);
      i++;
    end
    chk(nm, 32'(exp), host.q.size() ? 32'(host.q.pop_front()) : 32'hx);
  endtask : rxPop
  // Offer is held until the cycle in which it is taken
  task automatic rpl(input logic a, input logic ok, input logic [7:0] b, input logic l);
    int i;
    wt(1);
    ackReq = a;
    ackOk = ok;
    rspValid = ~a;
    rspByte = b;
    rspLast = l;
    i = 0;
    while (rspReady !== 1'b1 && i < 3000)
    begin
      wt(1);
      i++;
    end
    wt(1);
    ackReq = 1'b0;
    rspValid = 1'b0;
  endtask : rpl
  task automatic train(input int per);
    host.per = per;
    host.sendByte(8'h55);
    wt(8);
  endtask : train
  // ********
  // Scenarios
  // ********
  task automatic tLock();
    chk("locked", 32'h0, 32'(locked));
    chk("rstPinOeN", 32'h1, 32'(rstPinOeN));
    train(16);
    rxPop("ack", ACK_BYTE);
    chk("bitPeriod", 32'h10, 32'(bitPeriod));
    $display("test lock done");
  endtask : tLock
  task automatic tCmd();
    logic [7:0] b[3];
    b = '{8'ha5, 8'h0d, 8'h00};
    cbq.delete();
    cpq.delete();
    foreach (b[i]) host.sendByte(b[i]);
    chk("count", 32'h3, 32'(cbq.size()));
    foreach (b[i])
    begin
      chk("cmdByte", 32'(b[i]), 32'(cbq[i]));
      chk("cmdPos", 32'(i), 32'(cpq[i]));
    end
    chk("cmdBusy", 32'h1, 32'(cmdBusy));
    rpl(1'b1, 1'b0, 8'h00, 1'b0);
    rxPop("nak", NAK_BYTE);
    chk("cmdBusy", 32'h0, 32'(cmdBusy));
    cpq.delete();
    host.sendByte(8'h3c);
    chk("count", 32'h1, 32'(cpq.size()));
    chk("cmdPos", 32'h0, 32'(cpq[0]));
    rpl(1'b1, 1'b1, 8'h00, 1'b0);
    rxPop("ack", ACK_BYTE);
    $display("test command done");
  endtask : tCmd
  task automatic tReply();
    host.sendByte(8'h41);
    rpl(1'b0, 1'b0, 8'h12, 1'b0);
    rpl(1'b0, 1'b0, 8'h00, 1'b0);
    rpl(1'b0, 1'b0, 8'hff, 1'b1);
    rxPop("rsp0", 8'h12);
    rxPop("rsp1", 8'h00);
    rxPop("rsp2", 8'hff);
    chk("cmdBusy", 32'h0, 32'(cmdBusy));
    $display("test reply done");
  endtask : tReply
  task automatic tPin();
    host.pullPin(400);
    wt(4);
    chk("locked", 32'h1, 32'(locked));
    fork
      host.pullPin(510);
      begin
        wt(505);
        chk("pinReset", 32'h1, 32'(pinReset));
      end
    join
    wt(4);
    chk("bitPeriod", 32'h0, 32'(bitPeriod));
    host.q.delete();
    train(40);
    rxPop("ack", ACK_BYTE);
    chk("bitPeriod", 32'h28, 32'(bitPeriod));
    $display("test pin reset done");
  endtask : tPin
  task automatic tRange();
    reset = 1'b1;
    wt(2);
    reset = 1'b0;
    wt(2);
    chk("locked", 32'h0, 32'(locked));
    train(80);
    wt(700);
    chk("slow", 32'h0, 32'(host.q.size()));
    train(8);
    rxPop("ack", ACK_BYTE);
    chk("bitPeriod", 32'h8, 32'(bitPeriod));
    $display("test range done");
  endtask : tRange
  task automatic printVerdict();
    $display("checks %0d mismatches %0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : printVerdict
  initial
  begin
    rspValid = 1'b0;
    rspLast = 1'b0;
    ackReq = 1'b0;
    ackOk = 1'b0;
    rspByte = 8'h00;
    wt(16);
    reset = 1'b0;
    wt(2);
    tLock();
    tCmd();
    tReply();
    tPin();
    tRange();
    printVerdict();
  end
endmodule : tb_uacl_link

// ### uacl_byte_if.sv
// Byte stream plus bit period between the link core and its serial engines
`timescale 1ns/1ps
interface uacl_byte_if #(parameter int unsigned PW = 20);
  logic [7:0] data;
  logic valid;
  logic ready;
  logic [PW-1:0] bitPeriod;

  modport lineRx (output data, output valid, input bitPeriod);
  modport coreRx (input data, input valid, output bitPeriod);
  modport coreTx (output data, output valid, output bitPeriod, input ready);
  modport lineTx (input data, input valid, input bitPeriod, output ready);
endinterface : uacl_byte_if

// ### uacl_host_model.sv
// Host model: serial sender, serial receiver, open-drain reset pull
`timescale 1ns/1ps
module uacl_host_model (
  input wire logic core_clk, // Clock
  input wire logic txLine, // From link
  output logic rxLine, // To link
  output logic hostPull // Pulls pin low
);
  int per = 16;
  logic [7:0] q[$];
  logic [7:0] d;
  initial rxLine = 1'b1;
  initial hostPull = 1'b0;
  task automatic sendByte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rxLine = f[i];
      repeat (per) @(negedge core_clk);
    end
  endtask : sendByte
  // Only pulls or releases, never drives the pin high
  task automatic pullPin(input int n);
    hostPull = 1'b1;
    repeat (n) @(negedge core_clk);
    hostPull = 1'b0;
  endtask : pullPin
  // Mid-bit sampling; a frame with a low stop bit is dropped
  always
  begin
    @(negedge core_clk iff txLine === 1'b0);
    repeat (per / 2) @(negedge core_clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (per) @(negedge core_clk);
      d[i] = txLine;
    end
    repeat (per) @(negedge core_clk);
    if (txLine === 1'b1)
      q.push_back(d);
  end
endmodule : uacl_host_model

// ### uacl_link.sv
// Autobaud serial command link: rate training, byte framing and reply path
`timescale 1ns/1ps

module uacl_link #(
  parameter int unsigned PER_MAX = uacl_pkg::PER_MAX_CYC,
  parameter int unsigned PER_MIN = uacl_pkg::PER_MIN_CYC
) (
  input wire logic core_clk, // Core clock, 250 MHz
  input wire logic reset, // Synchronous reset, active high
  input wire logic rxLine, // Serial data from the host
  output logic txLine, // Serial data to the host
  input wire logic rstPinIn, // Level seen on the reset pin
  output logic rstPinOut, // Reset pin output level
  output logic rstPinOeN, // Reset pin enable, low would drive
  output logic pinReset, // Reset pin has been low long enough
  output logic locked, // Bit rate is locked
  output logic [uacl_pkg::PER_W-1:0] bitPeriod, // Locked bit period in cycles
  output logic [7:0] cmdByte, // Received command byte
  output logic cmdValid, // One-cycle strobe for cmdByte
  output logic [uacl_pkg::POS_W-1:0] cmdPos, // Position of cmdByte in its command
  output logic cmdBusy, // A command awaits its reply
  input wire logic rspValid, // Dedicated reply byte offered
  input wire logic [7:0] rspByte, // Dedicated reply byte
  input wire logic rspLast, // Offered byte ends the reply
  input wire logic ackReq, // Request a one-byte status reply
  input wire logic ackOk, // Status reply is success, else failure
  output logic rspReady // Reply byte is taken this cycle
);
  import uacl_pkg::*;

  // ****************************************************************
  // Accepted bit period window
  // ****************************************************************
  // A little slack each side covers host clock error
  localparam logic [PER_W-1:0] PerHi = PER_W'(PER_MAX + (PER_MAX >> PER_SLACK_SHIFT));
  localparam logic [PER_W-1:0] PerLo = PER_W'(PER_MIN - (PER_MIN >> PER_SLACK_SHIFT));
  localparam logic [TRN_W-1:0] TrainLimit = TRN_W'(8 * (PER_MAX + (PER_MAX >> PER_SLACK_SHIFT)));

  uacl_byte_if #(.PW(PER_W)) rxIf ();
  uacl_byte_if #(.PW(PER_W)) txIf ();

  logic [RST_CNT_W-1:0] rstLowCnt_q;
  logic coreRst;
  uacl_lock_t state_q;
  logic rxPrev_q;
  logic [TRN_W-1:0] trainCnt_q;
  logic [2:0] edgeCnt_q;
  logic [TRN_W-1:0] trainTot;
  logic [PER_W-1:0] perMeas;
  logic lineEdge;
  logic [POS_W-1:0] posCnt_q;
  logic [POS_W-1:0] posBase;
  logic [7:0] hold_q;
  logic holdValid_q;
  logic holdLast_q;
  logic accept;
  logic txTaken;
  logic endCmd;
  logic loadAck;

  // ****************************************************************
  // Reset pin
  // ****************************************************************
  // Only a low level held past the minimum counts; shorter dips are noise
  always_ff @(posedge core_clk)
  begin
    if (reset || rstPinIn)
    begin
      rstLowCnt_q <= '0;
      pinReset <= 1'b0;
    end
    else
    begin
      if (rstLowCnt_q != RST_LOW_LAST)
        rstLowCnt_q <= rstLowCnt_q + 1'b1;
      pinReset <= (rstLowCnt_q == RST_LOW_LAST);
    end
  end

  // Pin reset clears all that the core reset clears, the rate lock too
  assign coreRst = reset || pinReset;

  // The pin is an input only; the driver stays released for good
  always_ff @(posedge core_clk)
  begin
    rstPinOut <= 1'b1;
    rstPinOeN <= 1'b1;
  end

  // ****************************************************************
  // Rate training
  // ****************************************************************
  always_ff @(posedge core_clk)
  begin
    rxPrev_q <= coreRst ? 1'b1 : rxLine;
  end

  // Any change of level counts as an edge while training
  assign lineEdge = (rxPrev_q != rxLine);
  // Start fall to the last data fall spans eight bit times
  assign trainTot = trainCnt_q + 1'b1;
  assign perMeas = PER_W'(trainTot >> TRAIN_SHIFT);

  always_ff @(posedge core_clk)
  begin
    if (coreRst)
    begin
      state_q <= LK_HUNT;
      trainCnt_q <= '0;
      edgeCnt_q <= 3'h0;
      bitPeriod <= '0;
      locked <= 1'b0;
    end
    else
    begin
      case (state_q)
        LK_HUNT:
        begin
          trainCnt_q <= '0;
          edgeCnt_q <= 3'h0;
          if (rxPrev_q && !rxLine)
            state_q <= LK_TRAIN;
        end
        LK_TRAIN:
        begin
          trainCnt_q <= trainCnt_q + 1'b1;
          if (lineEdge)
          begin
            edgeCnt_q <= edgeCnt_q + 1'b1;
            if (edgeCnt_q == TRAIN_LAST_EDGE)
            begin
              // Rates outside the supported range are discarded
              if (perMeas >= PerLo && perMeas <= PerHi)
              begin
                bitPeriod <= perMeas;
                state_q <= LK_STOPWAIT;
              end
              else
                state_q <= LK_HUNT;
            end
          end
          else if (trainCnt_q == TrainLimit)
            state_q <= LK_HUNT;
        end
        LK_STOPWAIT:
        begin
          // Last data bit is low; the stop bit rise ends training
          if (rxLine)
            state_q <= LK_ACK;
        end
        LK_ACK:
        begin
          if (!holdValid_q)
          begin
            state_q <= LK_RUN;
            locked <= 1'b1;
          end
        end
        LK_RUN: state_q <= LK_RUN;
        default: state_q <= LK_HUNT;
      endcase
    end
  end

  // ****************************************************************
  // Serial engines
  // ****************************************************************
  assign rxIf.bitPeriod = bitPeriod;
  assign txIf.bitPeriod = bitPeriod;
  assign txIf.valid = holdValid_q;
  assign txIf.data = hold_q;

  uacl_rx u_rx (
    .core_clk(core_clk),
    .reset(coreRst),
    .enable(locked),
    .rxLine(rxLine),
    .rxIf(rxIf)
  );

  uacl_tx u_tx (
    .core_clk(core_clk),
    .reset(coreRst),
    .txLine(txLine),
    .txIf(txIf)
  );

  // ****************************************************************
  // Command bytes
  // ****************************************************************
  assign txTaken = holdValid_q && txIf.ready;
  assign endCmd = txTaken && holdLast_q;
  // A byte arriving as the reply ends opens the next command
  assign posBase = endCmd ? '0 : posCnt_q;

  always_ff @(posedge core_clk)
  begin
    if (coreRst)
    begin
      cmdValid <= 1'b0;
      cmdByte <= 8'h00;
      cmdPos <= '0;
      posCnt_q <= '0;
    end
    else
    begin
      cmdValid <= rxIf.valid;
      posCnt_q <= posBase;
      if (rxIf.valid)
      begin
        cmdByte <= rxIf.data;
        cmdPos <= posBase;
        if (posBase != POS_SAT)
          posCnt_q <= posBase + 1'b1;
      end
    end
  end

  // Set by a new byte wins over the clear by the reply's last byte
  always_ff @(posedge core_clk)
  begin
    if (coreRst)
      cmdBusy <= 1'b0;
    else if (rxIf.valid)
      cmdBusy <= 1'b1;
    else if (endCmd)
      cmdBusy <= 1'b0;
  end

  // ****************************************************************
  // Reply path
  // ****************************************************************
  // One holding byte; the offer is taken only while it is empty
  assign accept = rspReady && (ackReq || rspValid);
  assign loadAck = (state_q == LK_ACK) && !holdValid_q;

  always_ff @(posedge core_clk)
  begin
    if (coreRst)
    begin
      hold_q <= 8'h00;
      holdValid_q <= 1'b0;
      holdLast_q <= 1'b0;
    end
    else if (loadAck)
    begin
      hold_q <= ACK_BYTE;
      holdValid_q <= 1'b1;
      holdLast_q <= 1'b0;
    end
    else if (accept)
    begin
      holdValid_q <= 1'b1;
      if (ackReq)
      begin
        // Status reply is one byte; unknown codes come here as failure
        hold_q <= ackOk ? ACK_BYTE : NAK_BYTE;
        holdLast_q <= 1'b1;
      end
      else
      begin
        hold_q <= rspByte;
        holdLast_q <= rspLast;
      end
    end
    else if (txTaken)
      holdValid_q <= 1'b0;
  end

  // Ready is a flop, so it looks one cycle ahead at the holding byte
  always_ff @(posedge core_clk)
  begin
    if (coreRst)
      rspReady <= 1'b0;
    else
      rspReady <= locked && !accept && (!holdValid_q || txTaken);
  end

endmodule : uacl_link

// ### uacl_link_asserts.sv
// Port-level concurrent checks for the autobaud command link
`timescale 1ns/1ps
module uacl_link_asserts #(
  parameter int unsigned PER_MAX = uacl_pkg::PER_MAX_CYC,
  parameter int unsigned PER_MIN = uacl_pkg::PER_MIN_CYC
) (
  input wire logic core_clk, // Clock
  input wire logic reset, // Reset
  input wire logic rxLine, // Host data
  input wire logic txLine, // Link data
  input wire logic rstPinIn, // Pin level
  input wire logic rstPinOut, // Pin out
  input wire logic rstPinOeN, // Pin enable
  input wire logic pinReset, // Pin reset
  input wire logic locked, // Rate locked
  input wire logic [uacl_pkg::PER_W-1:0] bitPeriod, // Period
  input wire logic [7:0] cmdByte, // Byte
  input wire logic cmdValid, // Byte strobe
  input wire logic [uacl_pkg::POS_W-1:0] cmdPos, // Position
  input wire logic cmdBusy, // Busy
  input wire logic rspValid, // Reply offer
  input wire logic [7:0] rspByte, // Reply byte
  input wire logic rspLast, // Reply end
  input wire logic ackReq, // Status req
  input wire logic ackOk, // Status ok
  input wire logic rspReady // Taken
);
  import uacl_pkg::*;
  logic [9:0] lowCnt;
  logic [POS_W-1:0] lastPos;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // ********
  // Helpers
  // ********
  // Counts consecutive low samples of the pin
  always_ff @(posedge core_clk)
  begin
    if (rstPinIn)
      lowCnt <= 10'h000;
    else if (lowCnt != 10'h3ff)
      lowCnt <= lowCnt + 10'h001;
  end
  always_ff @(posedge core_clk)
  begin
    if (cmdValid)
      lastPos <= cmdPos;
  end
  // ********
  // Checks
  // ********
  a_pin_released: assert property (rstPinOeN && rstPinOut)
    else $error("reset pin driven");
  a_reset_values: assert property (disable iff (1'b0) reset |=>
    !locked && bitPeriod == '0 && txLine && !rspReady && !cmdBusy) else $error("reset values");
  a_pin_short: assert property ($rose(pinReset) |-> lowCnt >= RST_LOW_CYC)
    else $error("short pulse reset");
  a_pin_long: assert property (lowCnt >= RST_LOW_CYC + 2 |-> pinReset)
    else $error("long pulse missed");
  a_pin_unlocks: assert property (pinReset |=> !locked)
    else $error("lock kept");
  a_ack_on_lock: assert property ($rose(locked) |-> ##[0:3] !txLine)
    else $error("no ack start");
  a_idle_high: assert property (!locked |-> txLine && !rspReady)
    else $error("line not idle");
  a_take_sends: assert property (rspReady && (ackReq || rspValid) |=>
    !rspReady ##[0:1000] !txLine) else $error("reply not sent");
  a_busy_on_byte: assert property (cmdValid |-> ##[0:1] cmdBusy)
    else $error("busy missing");
  a_first_zero: assert property (cmdValid && !$past(cmdBusy) |-> cmdPos == '0)
    else $error("first pos");
  a_pos_steps: assert property (cmdValid && cmdPos != '0 && cmdPos != POS_SAT |->
    cmdPos == lastPos + 8'h01) else $error("pos step");
  a_period_held: assert property (locked && $past(locked) |-> $stable(bitPeriod))
    else $error("period moved");
  c_lock: cover property ($rose(locked));
  c_nak: cover property (rspReady && ackReq && !ackOk);
  c_pin: cover property ($rose(pinReset));
endmodule : uacl_link_asserts

bind uacl_link uacl_link_asserts #(.PER_MAX(PER_MAX), .PER_MIN(PER_MIN)) u_asserts (
  .core_clk(core_clk), .reset(reset), .rxLine(rxLine), .txLine(txLine), .rstPinIn(rstPinIn),
  .rstPinOut(rstPinOut), .rstPinOeN(rstPinOeN), .pinReset(pinReset), .locked(locked),
  .bitPeriod(bitPeriod), .cmdByte(cmdByte), .cmdValid(cmdValid), .cmdPos(cmdPos),
  .cmdBusy(cmdBusy), .rspValid(rspValid), .rspByte(rspByte), .rspLast(rspLast),
  .ackReq(ackReq), .ackOk(ackOk), .rspReady(rspReady)
);

// ### uacl_pkg.sv
// Constants and types shared by the autobaud command link
package uacl_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned RST_LOW_MIN_NS = 2000;
  localparam int unsigned RST_LOW_CYC = (RST_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RST_CNT_W = 9;
  localparam logic [RST_CNT_W-1:0] RST_LOW_LAST = RST_CNT_W'(RST_LOW_CYC - 1);

  // ****************************************************************
  // Bit rate range and training
  // ****************************************************************
  localparam int unsigned BAUD_MIN = 300;
  localparam int unsigned BAUD_MAX = 256_000;
  localparam int unsigned PER_MAX_CYC = CLK_HZ / BAUD_MIN;
  localparam int unsigned PER_MIN_CYC = CLK_HZ / BAUD_MAX;
  localparam int unsigned PER_SLACK_SHIFT = 4;
  localparam int unsigned PER_W = 20;
  localparam int unsigned TRN_W = 23;
  localparam int unsigned TRAIN_SHIFT = 3;
  localparam logic [2:0] TRAIN_LAST_EDGE = 3'h7;

  // ****************************************************************
  // Characters
  // ****************************************************************
  localparam logic [7:0] ACK_BYTE = 8'h06;
  localparam logic [7:0] NAK_BYTE = 8'h15;
  localparam int unsigned POS_W = 8;
  localparam logic [POS_W-1:0] POS_SAT = 8'hff;

  typedef enum logic [2:0] {LK_HUNT, LK_TRAIN, LK_STOPWAIT, LK_ACK, LK_RUN} uacl_lock_t;

endpackage : uacl_pkg

// ### uacl_rx.sv
// Serial receiver timed by a measured bit period
`timescale 1ns/1ps
module uacl_rx (
  input wire logic core_clk, // Core clock
  input wire logic reset, // Synchronous reset
  input wire logic enable, // Receive only once the rate is locked
  input wire logic rxLine, // Serial line from the host
  uacl_byte_if.lineRx rxIf // Received bytes
);
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uacl_rx_t;
  uacl_rx_t state_q;
  logic prev_q;
  logic [$bits(rxIf.bitPeriod)-1:0] tick_q;
  logic [2:0] idx_q;
  logic [7:0] shift_q;
  logic valid_q;
  logic [7:0] data_q;
  logic bitEnd;

  assign bitEnd = (tick_q == rxIf.bitPeriod - 1'b1);
  assign rxIf.valid = valid_q;
  assign rxIf.data = data_q;

  always_ff @(posedge core_clk)
  begin
    prev_q <= reset ? 1'b1 : rxLine;
  end

  // Start, 8 data bits LSB first, one stop bit; no parity
  always_ff @(posedge core_clk)
  begin
    valid_q <= 1'b0;
    if (reset || !enable)
    begin
      state_q <= RX_IDLE;
      tick_q <= '0;
      idx_q <= 3'h0;
      shift_q <= 8'h00;
      data_q <= 8'h00;
    end
    else
    begin
      tick_q <= tick_q + 1'b1;
      case (state_q)
        RX_IDLE:
        begin
          tick_q <= '0;
          if (prev_q && !rxLine)
            state_q <= RX_START;
        end
        RX_START:
        begin
          // Recheck mid start bit so a glitch is not taken as a character
          if (tick_q == (rxIf.bitPeriod >> 1))
          begin
            tick_q <= '0;
            idx_q <= 3'h0;
            state_q <= rxLine ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA:
        begin
          if (bitEnd)
          begin
            tick_q <= '0;
            shift_q <= {rxLine, shift_q[7:1]};
            idx_q <= idx_q + 1'b1;
            if (idx_q == 3'h7)
              state_q <= RX_STOP;
          end
        end
        RX_STOP:
        begin
          // A missing stop bit drops the character
          if (bitEnd)
          begin
            state_q <= RX_IDLE;
            valid_q <= rxLine;
            data_q <= shift_q;
          end
        end
        default: state_q <= RX_IDLE;
      endcase
    end
  end
endmodule : uacl_rx

// ### uacl_tx.sv
// Serial transmitter timed by a measured bit period
`timescale 1ns/1ps
module uacl_tx (
  input wire logic core_clk, // Core clock
  input wire logic reset, // Synchronous reset
  output logic txLine, // Serial line to the host
  uacl_byte_if.lineTx txIf // Bytes to send
);
  typedef enum logic {TX_IDLE, TX_SEND} uacl_tx_t;
  uacl_tx_t state_q;
  logic [$bits(txIf.bitPeriod)-1:0] tick_q;
  logic [3:0] idx_q;
  logic [8:0] shift_q;

  assign txIf.ready = (state_q == TX_IDLE);

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state_q <= TX_IDLE;
      txLine <= 1'b1;
      tick_q <= '0;
      idx_q <= 4'h0;
      shift_q <= 9'h1ff;
    end
    else
    begin
      case (state_q)
        TX_IDLE:
        begin
          txLine <= 1'b1;
          if (txIf.valid)
          begin
            state_q <= TX_SEND;
            txLine <= 1'b0;
            shift_q <= {1'b1, txIf.data};
            tick_q <= '0;
            idx_q <= 4'h0;
          end
        end
        TX_SEND:
        begin
          tick_q <= tick_q + 1'b1;
          if (tick_q == txIf.bitPeriod - 1'b1)
          begin
            tick_q <= '0;
            idx_q <= idx_q + 1'b1;
            if (idx_q == 4'h9)
              state_q <= TX_IDLE;
            else
            begin
              txLine <= shift_q[0];
              shift_q <= {1'b1, shift_q[8:1]};
            end
          end
        end
        default: state_q <= TX_IDLE;
      endcase
    end
  end
endmodule : uacl_tx
